// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the conditional branch evaluator
// Assumes: Inputs change on the falling edge of REF_CLK
// Notes:   Tracks the expected program counter beside the design
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import branch_pkg::*;
    logic            ref_clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            pc_load = 1'b0;
    logic [PC_W-1:0] ld_val = 16'h0000;
    jump_req_t       req = '0;
    flags_t          fl = '0;
    logic [PC_W-1:0] pc;
    flags_t          fo;
    logic            taken;
    logic            done;
    logic [PC_W-1:0] exp_pc = 16'h0000;
    int              mismatches = 0;
    int              checks = 0;
    int              cycles = 0;
    conditional_branch_evaluator uut (.REF_CLK(ref_clk), .RST_N(rst_n), .JUMP_REQ(req), .FLAGS_IN(fl),
        .PC_LOAD(pc_load), .PC_LOAD_VAL(ld_val), .PROGRAM_COUNTER(pc), .FLAGS_OUT(fo), .TAKEN(taken), .DONE(done));
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            print_verdict();
        end
    end
    function automatic logic want(cond_t c, flags_t f);
        case (c)
            COND_JUMP_IF_PLUS:             return !f.n;
            COND_JUMP_IF_MINUS:            return f.n;
            COND_JUMP_IF_EQUAL:            return f.z;
            COND_JUMP_IF_NOT_EQUAL:        return !f.z;
            COND_JUMP_IF_CARRY:            return f.c;
            COND_JUMP_IF_NO_CARRY:         return !f.c;
            COND_JUMP_IF_UNSIGNED_GREATER: return !(f.c | f.z);
            COND_JUMP_IF_UNSIGNED_LESS_EQUAL: return f.c | f.z;
            COND_ALWAYS:                   return 1'b1;
            default:                       return 1'b0;
        endcase
    endfunction
    task automatic check(string what, logic [PC_W-1:0] seen, logic [PC_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic jump(cond_t c, flags_t f, logic [OFS_W-1:0] ofs);
        logic t;
        t = want(c, f);
        req = '{1'b1, c, ofs};
        fl = f;
        @(negedge ref_clk);
        exp_pc = exp_pc + 16'h0002 + (t ? {{8{ofs[7]}}, ofs} : 16'h0000);
        check("done", {15'h0000, done}, 16'h0001);
        check("taken", {15'h0000, taken}, {15'h0000, t});
        check("pc", pc, exp_pc);
        check("flags", {11'h000, fo}, {11'h000, f});
    endtask
    task automatic test_conditions();
        for (int i = 0; i < 16; i++)
            for (int f = 0; f < 32; f++)
                jump(cond_t'(i[3:0]), flags_t'(f[4:0]), 8'h05);
        req = '0;
        @(negedge ref_clk);
        check("done_drop", {15'h0000, done}, 16'h0000);
        check("pc_hold", pc, exp_pc);
    endtask
    task automatic test_offsets();
        jump(COND_JUMP_IF_EQUAL, flags_t'(5'h02), 8'h7F);
        jump(COND_JUMP_IF_EQUAL, flags_t'(5'h02), 8'h80);
        jump(COND_JUMP_IF_EQUAL, flags_t'(5'h02), 8'hFE);
        jump(COND_JUMP_IF_NOT_EQUAL, flags_t'(5'h02), 8'h80);
        req = '0;
        @(negedge ref_clk);
    endtask
    task automatic test_load();
        pc_load = 1'b1;
        ld_val = 16'hFFF0;
        req = '{1'b1, COND_JUMP_IF_EQUAL, 8'h10};
        @(negedge ref_clk);
        pc_load = 1'b0;
        exp_pc = 16'hFFF0;
        check("load_pc", pc, exp_pc);
        check("load_done", {15'h0000, done}, 16'h0000);
        check("load_taken", {15'h0000, taken}, 16'h0000);
        jump(COND_JUMP_IF_EQUAL, flags_t'(5'h02), 8'h20);
        req = '0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        check("reset_pc", pc, 16'h0000);
        check("reset_out", {14'h0000, taken, done}, 16'h0000);
        check("reset_flags", {11'h000, fo}, 16'h0000);
        rst_n = 1'b1;
        test_conditions();
        test_offsets();
        test_load();
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- hdl/conditional_branch_evaluator.sv ----
// Purpose: Evaluates conditional relative jumps and updates the program counter
// Assumes: Condition flags and jump request come from logic on REF_CLK
// Notes:   Program counter points at the jump; fallthrough skips the two instruction bytes
// How it works
// - Plus jump taken only when negative flag is clear.
// - Equal jump taken only when zero flag is set.
// - Not-equal jump taken only when zero flag is clear.
// - Unsigned-greater jump taken when carry OR zero equals zero.
// - Unsigned-less-equal jump taken when carry OR zero equals one.
// - Taken jump adds the two instruction bytes plus sign-extended 8-bit offset to program counter.
// - Minus jump taken only when negative flag is set.
`timescale 1ns/1ps
`default_nettype none
module conditional_branch_evaluator (
    input  wire logic                         REF_CLK,
    input  wire logic                         RST_N,
    input  wire branch_pkg::jump_req_t        JUMP_REQ,
    input  wire branch_pkg::flags_t           FLAGS_IN,
    input  wire logic                         PC_LOAD,
    input  wire logic [branch_pkg::PC_W-1:0]  PC_LOAD_VAL,
    output logic [branch_pkg::PC_W-1:0]       PROGRAM_COUNTER,
    output branch_pkg::flags_t                FLAGS_OUT,
    output logic                              TAKEN,
    output logic                              DONE
);
    import branch_pkg::*;

    state_t s_q;
    state_t s_d;

    function automatic logic cond_met(input cond_t c, input flags_t f);
        case (c)
            COND_JUMP_IF_PLUS:                cond_met = (f.n == 1'b0);
            COND_JUMP_IF_MINUS:               cond_met = (f.n == 1'b1);
            COND_JUMP_IF_EQUAL:               cond_met = (f.z == 1'b1);
            COND_JUMP_IF_NOT_EQUAL:           cond_met = (f.z == 1'b0);
            COND_JUMP_IF_CARRY:               cond_met = (f.c == 1'b1);
            COND_JUMP_IF_NO_CARRY:            cond_met = (f.c == 1'b0);
            COND_JUMP_IF_UNSIGNED_GREATER:    cond_met = ((f.c | f.z) == 1'b0);
            COND_JUMP_IF_UNSIGNED_LESS_EQUAL: cond_met = ((f.c | f.z) == 1'b1);
            COND_ALWAYS:                      cond_met = 1'b1;
            default:                          cond_met = 1'b0;
        endcase
    endfunction

    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc, input logic [OFS_W-1:0] ofs);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
        rel_target = pc + PC_W'(INSTR_LEN) + ext;
    endfunction

    logic met;

    always_comb begin
        s_d      = s_q;
        met      = cond_met(JUMP_REQ.cond, FLAGS_IN);
        s_d.done = 1'b0;
        s_d.flags = FLAGS_IN;
        if (PC_LOAD) begin
            s_d.pc    = PC_LOAD_VAL;
            s_d.taken = 1'b0;
        end else if (JUMP_REQ.valid) begin
            s_d.done  = 1'b1;
            s_d.taken = met;
            if (met) begin
                s_d.pc = rel_target(s_q.pc, JUMP_REQ.offset);
            end else begin
                s_d.pc = s_q.pc + PC_W'(INSTR_LEN);
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            s_q <= '{pc: PC_RST, flags: '0, taken: 1'b0, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign PROGRAM_COUNTER = s_q.pc;
    assign FLAGS_OUT       = s_q.flags;
    assign TAKEN           = s_q.taken;
    assign DONE            = s_q.done;

    sequence jump_req(cond_t c);
        JUMP_REQ.valid && !PC_LOAD && JUMP_REQ.cond == c;
    endsequence

    a_plus_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_JUMP_IF_PLUS) |=> TAKEN == !$past(FLAGS_IN.n))
        else $error("Plus jump decision wrong");
    a_minus_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_JUMP_IF_MINUS) |=> TAKEN == $past(FLAGS_IN.n))
        else $error("Minus jump decision wrong");
    a_equal_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_JUMP_IF_EQUAL) |=> TAKEN == $past(FLAGS_IN.z))
        else $error("Equal jump decision wrong");
    a_not_equal: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_JUMP_IF_NOT_EQUAL) |=> TAKEN == !$past(FLAGS_IN.z))
        else $error("Not-equal jump decision wrong");
    a_unsigned_greater: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_JUMP_IF_UNSIGNED_GREATER) |=> TAKEN == !($past(FLAGS_IN.c) | $past(FLAGS_IN.z)))
        else $error("Unsigned greater decision wrong");
    a_unsigned_less_eq: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_JUMP_IF_UNSIGNED_LESS_EQUAL) |=> TAKEN == ($past(FLAGS_IN.c) | $past(FLAGS_IN.z)))
        else $error("Unsigned less-equal decision wrong");
    a_taken_target: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (JUMP_REQ.valid && !PC_LOAD) ##1 TAKEN |-> PROGRAM_COUNTER ==
        PC_W'($past(PROGRAM_COUNTER) + PC_W'(INSTR_LEN)
        + {{(PC_W-OFS_W){$past(JUMP_REQ.offset[OFS_W-1])}}, $past(JUMP_REQ.offset)}))
        else $error("Taken jump target wrong");
    a_fallthrough: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (JUMP_REQ.valid && !PC_LOAD) ##1 !TAKEN |-> PROGRAM_COUNTER ==
        PC_W'($past(PROGRAM_COUNTER) + PC_W'(INSTR_LEN)) && FLAGS_OUT == $past(FLAGS_IN))
        else $error("Untaken jump did not fall through");

    sequence accepted;
        JUMP_REQ.valid && !PC_LOAD;
    endsequence

    sequence idle_cycle;
        !JUMP_REQ.valid && !PC_LOAD;
    endsequence

    sequence load_cycle;
        PC_LOAD;
    endsequence

    sequence in_reset;
        !RST_N;
    endsequence

    a_carry_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_JUMP_IF_CARRY)
        |=> TAKEN == $past(FLAGS_IN.c))
        else $error("Carry jump decision wrong");

    a_carry_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_JUMP_IF_NO_CARRY)
        |=> TAKEN == !$past(FLAGS_IN.c))
        else $error("No-carry jump decision wrong");

    a_always_jump: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_ALWAYS)
        |=> TAKEN)
        else $error("Always jump not taken");

    a_never_jump: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        jump_req(COND_NEVER)
        |=> !TAKEN)
        else $error("Never jump was taken");

    a_spare_codes: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        JUMP_REQ.valid && !PC_LOAD && JUMP_REQ.cond > COND_NEVER
        |=> !TAKEN)
        else $error("Spare condition code was taken");

    a_done_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        accepted
        |=> DONE)
        else $error("Accepted jump gave no done pulse");

    a_done_idle: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        idle_cycle
        |=> !DONE)
        else $error("Done pulse without a jump");

    a_done_on_load: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        load_cycle
        |=> !DONE)
        else $error("Done pulse on a load");

    a_load_value: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        load_cycle
        |=> PROGRAM_COUNTER == $past(PC_LOAD_VAL))
        else $error("Load value not taken");

    a_load_clears: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        load_cycle
        |=> !TAKEN)
        else $error("Taken not cleared by a load");

    a_idle_pc_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        idle_cycle
        |=> $stable(PROGRAM_COUNTER))
        else $error("Program counter moved while idle");

    a_idle_taken_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        idle_cycle
        |=> $stable(TAKEN))
        else $error("Taken moved while idle");

    a_flags_copy: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        1'b1
        |=> FLAGS_OUT == $past(FLAGS_IN))
        else $error("Flags were modified");

    a_reset_state: assert property (@(posedge REF_CLK)
        in_reset
        |=> PROGRAM_COUNTER == PC_RST && !TAKEN && !DONE && FLAGS_OUT == '0)
        else $error("Reset state wrong");

    a_done_source: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        DONE
        |-> $past(JUMP_REQ.valid) && !$past(PC_LOAD))
        else $error("Done without an accepted jump");

    a_taken_rise: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        $rose(TAKEN)
        |-> $past(JUMP_REQ.valid) && !$past(PC_LOAD))
        else $error("Taken rose without a jump");

    a_taken_fall: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        $fell(TAKEN)
        |-> $past(JUMP_REQ.valid) || $past(PC_LOAD))
        else $error("Taken fell without a jump or load");

    a_load_priority: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        PC_LOAD && JUMP_REQ.valid
        |=> PROGRAM_COUNTER == $past(PC_LOAD_VAL) && !DONE)
        else $error("Jump beat a load");
endmodule
`default_nettype wire

// ---- include/branch_pkg.sv ----
// Purpose: Shared types and constants for the conditional branch evaluator
// Assumes: 8-bit core, 16-bit program counter
// Notes:   Condition codes cover the sign-flag, equality and unsigned relative jumps
package branch_pkg;
    localparam int PC_W     = 16;
    localparam int OFS_W    = 8;
    localparam int INSTR_LEN = 2;
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;

    typedef enum logic [3:0] {
        COND_JUMP_IF_PLUS             = 4'h0,
        COND_JUMP_IF_MINUS            = 4'h1,
        COND_JUMP_IF_EQUAL            = 4'h2,
        COND_JUMP_IF_NOT_EQUAL        = 4'h3,
        COND_JUMP_IF_CARRY            = 4'h4,
        COND_JUMP_IF_NO_CARRY         = 4'h5,
        COND_JUMP_IF_UNSIGNED_GREATER = 4'h6,
        COND_JUMP_IF_UNSIGNED_LESS_EQUAL = 4'h7,
        COND_ALWAYS                   = 4'h8,
        COND_NEVER                    = 4'h9
    } cond_t;

    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } flags_t;

    typedef struct packed {
        logic             valid;
        cond_t            cond;
        logic [OFS_W-1:0] offset;
    } jump_req_t;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        flags_t          flags;
        logic            taken;
        logic            done;
    } state_t;
endpackage
